/* inc/mcp_cfg.svh */
/*
  constants of the motion controller pin shell: register offsets,
  field widths, mode codes, reset values and timing counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH

// ----------------------------------------------------------------
// internal location offsets
// ----------------------------------------------------------------
`define MCP_OFS_FLAG 6'h00
`define MCP_OFS_MODE 6'h05
`define MCP_OFS_STATUS 6'h07
`define MCP_OFS_CMD 6'h08
`define MCP_OFS_TARGET 6'h0C
`define MCP_OFS_TIMER 6'h0F
`define MCP_OFS_POS0 6'h12
`define MCP_OFS_POS1 6'h13
`define MCP_OFS_POS2 6'h14
`define MCP_OFS_PH_ADV 6'h1F
`define MCP_OFS_MOVE 6'h29

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define MCP_ADDR_W 6
`define MCP_STAT_CFG_W 4
`define MCP_CMD_ZERO 8'h80
`define MCP_TIMER_RST 8'h40
`define MCP_MODE_IDLE 3'h0
`define MCP_MODE_POS 3'h1
`define MCP_MODE_PVEL 3'h2
`define MCP_MODE_TRAP 3'h3
`define MCP_MODE_IVEL 3'h4

// ----------------------------------------------------------------
// timing counts in clock cycles, and the timer load shift in bits
// ----------------------------------------------------------------
`define MCP_PWM_PERIOD 7'h64
`define MCP_FILT_DEPTH 3
`define MCP_TIMER_SHIFT 4

`endif

/* inc/mcp_pkg.sv */
/*
  types of the motion controller pin shell.
  assumes nothing of its surroundings.
*/
package mcp_pkg;

  // host strobes that travel together
  typedef struct packed {
    logic ale_n;
    logic cs_n;
    logic rd_wr_n;
    logic oe_n;
  } mcp_hstrb_t;

  // controller modes
  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_POS,
    ST_PVEL,
    ST_TRAP,
    ST_IVEL
  } mcp_state_t;

endpackage : mcp_pkg

/* hdl/mcp_filt.sv */
/*
  three-edge state delay filter for one encoder line.
  assumes an input synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "mcp_cfg.svh"

module mcp_filt #(
  parameter int DEPTH = `MCP_FILT_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);

  logic [DEPTH-1:0] hist_reg;

  // a level counts only once all samples agree
  wire all_hi = &hist_reg;
  wire all_lo = ~|hist_reg;

  // history shift and qualified output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hist_reg <= '0;
      dout <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[DEPTH-2:0], din};
      if (all_hi) dout <= 1'b1;
      else if (all_lo) dout <= 1'b0;
    end
  end

endmodule : mcp_filt

/* hdl/mcp_top.sv */
/*
  pin shell of the motion controller: multiplexed host port,
  encoder front end, emergency flags, sample timer, motor command,
  pwm and commutator outputs, status pins.
  assumes all inputs synchronous to clk_sys and clk_sys used as
  the controller's external clock.
*/
`timescale 1ns/1ps
`include "mcp_cfg.svh"

module mcp_top #(
  parameter int POS_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mcp_pkg::mcp_hstrb_t host_strb,
  input wire logic [5:0] muxed_addr_data_low_in,
  output logic [5:0] muxed_addr_data_low_out,
  output logic muxed_addr_data_low_oe,
  input wire logic [1:0] data_only_high_in,
  output logic [1:0] data_only_high_out,
  output logic data_only_high_oe,
  input wire logic [1:0] enc_quad_in,
  input wire logic index_in,
  input wire logic limit_n,
  input wire logic stop_n,
  input wire logic sync_n,
  output logic [7:0] motor_cmd_out,
  output logic pwm_pulse,
  output logic pwm_sign,
  output logic [3:0] phase_en_out,
  output logic prof_out,
  output logic init_out
);

  // ----------------------------------------------------------------
  // host port strobe edges
  // ----------------------------------------------------------------

  logic ale_q_reg;
  logic cs_q_reg;
  logic [5:0] addr_reg;
  logic [7:0] out_latch_reg;
  logic drv_reg;

  // whole bus word, high lines are data only
  wire [7:0] bus_data = {data_only_high_in, muxed_addr_data_low_in};
  wire ale_rise = host_strb.ale_n & ~ale_q_reg;
  wire cs_rise = host_strb.cs_n & ~cs_q_reg;

  // address seen by a transfer; a strobe in the same edge wins
  wire [5:0] addr_eff = ale_rise ? muxed_addr_data_low_in : addr_reg;
  wire wr_go = cs_rise & ~host_strb.rd_wr_n;
  wire rd_go = cs_rise & host_strb.rd_wr_n;

  // strobe history and address latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ale_q_reg <= 1'b1;
      cs_q_reg <= 1'b1;
      addr_reg <= '0;
    end else begin
      ale_q_reg <= host_strb.ale_n;
      cs_q_reg <= host_strb.cs_n;
      if (ale_rise) addr_reg <= muxed_addr_data_low_in;
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------

  logic [7:0] mem_reg [0:63];
  logic [`MCP_STAT_CFG_W-1:0] cfg_reg;
  logic limit_flag_reg;
  logic stop_flag_reg;
  mcp_pkg::mcp_state_t state_reg;
  mcp_pkg::mcp_state_t state_next;

  wire wr_status = wr_go & (addr_eff == `MCP_OFS_STATUS);
  wire wr_mode = wr_go & (addr_eff == `MCP_OFS_MODE);
  wire wr_cmd = wr_go & (addr_eff == `MCP_OFS_CMD);
  wire is_idle = (state_reg == mcp_pkg::ST_IDLE);

  // generic storage, one byte per location
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) mem_reg[i] <= 8'h00;
      mem_reg[`MCP_OFS_TIMER] <= `MCP_TIMER_RST;
    end else if (wr_go) begin
      mem_reg[addr_eff] <= bus_data;
    end
  end

  // ----------------------------------------------------------------
  // emergency flags and status configuration
  // ----------------------------------------------------------------

  // set by a low pin; cleared by status write only once pin is high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limit_flag_reg <= 1'b0;
      stop_flag_reg <= 1'b0;
      cfg_reg <= '0;
    end else begin
      if (!limit_n) limit_flag_reg <= 1'b1;
      else if (wr_status) limit_flag_reg <= 1'b0;
      if (!stop_n) stop_flag_reg <= 1'b1;
      else if (wr_status) stop_flag_reg <= 1'b0;
      if (wr_status) cfg_reg <= bus_data[3:0];
    end
  end

  // ----------------------------------------------------------------
  // encoder front end
  // ----------------------------------------------------------------

  logic [2:0] filt_q;
  logic [1:0] ab_q_reg;
  logic idx_q_reg;
  logic [POS_W-1:0] pos_reg;
  logic [7:0] ring_reg;

  wire [2:0] raw_in = {index_in, enc_quad_in};

  // one filter per encoder line
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      mcp_filt #(
        .DEPTH(`MCP_FILT_DEPTH)
      ) u_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din(raw_in[g]),
        .dout(filt_q[g])
      );
    end
  endgenerate

  // ab as {a, b}; counting up follows 00, 01, 11, 10
  wire [1:0] ab = {filt_q[0], filt_q[1]};
  wire cnt_up = (ab_q_reg == 2'b00 && ab == 2'b01) ||
                (ab_q_reg == 2'b01 && ab == 2'b11) ||
                (ab_q_reg == 2'b11 && ab == 2'b10) ||
                (ab_q_reg == 2'b10 && ab == 2'b00);
  wire cnt_dn = (ab_q_reg == 2'b00 && ab == 2'b10) ||
                (ab_q_reg == 2'b10 && ab == 2'b11) ||
                (ab_q_reg == 2'b11 && ab == 2'b01) ||
                (ab_q_reg == 2'b01 && ab == 2'b00);

  // falling edge is a fixed mark for either pulse polarity
  wire idx_fall = idx_q_reg & ~filt_q[2];

  // position counter and commutator ring counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ab_q_reg <= 2'b00;
      idx_q_reg <= 1'b0;
      pos_reg <= '0;
      ring_reg <= 8'h00;
    end else begin
      ab_q_reg <= ab;
      idx_q_reg <= filt_q[2];
      if (cnt_up) pos_reg <= pos_reg + 1'b1;
      else if (cnt_dn) pos_reg <= pos_reg - 1'b1;
      if (idx_fall) ring_reg <= 8'h00;
      else if (cnt_up) ring_reg <= ring_reg + 1'b1;
      else if (cnt_dn) ring_reg <= ring_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sample timer
  // ----------------------------------------------------------------

  logic [11:0] tmr_reg;

  wire [11:0] tmr_load = {mem_reg[`MCP_OFS_TIMER], 4'h0};
  wire tmr_hold = is_idle & ~sync_n;
  wire sample_tick = ~tmr_hold & (tmr_reg == 12'h000);

  // countdown, reloaded at zero; sync low in idle pins it at zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= 12'h000;
    end else if (tmr_hold) begin
      tmr_reg <= 12'h000;
    end else if (sample_tick) begin
      tmr_reg <= tmr_load;
    end else begin
      tmr_reg <= tmr_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------

  // requested mode from a host write to the mode location
  wire [2:0] mode_code = bus_data[2:0];
  wire req_pos = wr_mode & (mode_code == `MCP_MODE_POS);
  wire req_pvel = wr_mode & (mode_code == `MCP_MODE_PVEL);
  wire req_trap = wr_mode & (mode_code == `MCP_MODE_TRAP);
  wire req_ivel = wr_mode & (mode_code == `MCP_MODE_IVEL);
  wire req_idle = wr_mode & (mode_code == `MCP_MODE_IDLE);

  // next mode; the limit flag overrides any request
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mcp_pkg::ST_RESET: state_next = mcp_pkg::ST_IDLE;
      mcp_pkg::ST_IDLE,
      mcp_pkg::ST_POS,
      mcp_pkg::ST_PVEL,
      mcp_pkg::ST_TRAP,
      mcp_pkg::ST_IVEL: begin
        if (req_pos) state_next = mcp_pkg::ST_POS;
        else if (req_pvel) state_next = mcp_pkg::ST_PVEL;
        else if (req_trap) state_next = mcp_pkg::ST_TRAP;
        else if (req_ivel) state_next = mcp_pkg::ST_IVEL;
        else if (req_idle) state_next = mcp_pkg::ST_IDLE;
      end
      default: state_next = mcp_pkg::ST_IDLE;
    endcase
    if (limit_flag_reg && state_reg != mcp_pkg::ST_RESET) begin
      state_next = mcp_pkg::ST_IDLE;
    end
  end

  // mode register, reset mode after a hard reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) state_reg <= mcp_pkg::ST_RESET;
    else state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // motor command
  // ----------------------------------------------------------------

  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] move_cnt_reg;

  wire [7:0] target = mem_reg[`MCP_OFS_TARGET];
  wire [7:0] ivel_goal = stop_flag_reg ? `MCP_CMD_ZERO : target;
  wire ivel_up = cmd_reg < ivel_goal;
  wire ivel_dn = cmd_reg > ivel_goal;
  wire run_mode = ~is_idle & (state_reg != mcp_pkg::ST_RESET);
  wire trap_enter = (state_next == mcp_pkg::ST_TRAP) &
                    (state_reg != mcp_pkg::ST_TRAP);

  // command per mode; integral velocity ramps one step per sample
  always_comb begin
    cmd_next = cmd_reg;
    case (state_reg)
      mcp_pkg::ST_RESET: cmd_next = `MCP_CMD_ZERO;
      mcp_pkg::ST_IDLE: begin
        if (wr_cmd) cmd_next = bus_data;
      end
      mcp_pkg::ST_POS,
      mcp_pkg::ST_PVEL,
      mcp_pkg::ST_TRAP: begin
        if (sample_tick) cmd_next = target;
      end
      mcp_pkg::ST_IVEL: begin
        if (sample_tick && ivel_up) cmd_next = cmd_reg + 1'b1;
        else if (sample_tick && ivel_dn) cmd_next = cmd_reg - 1'b1;
      end
      default: cmd_next = `MCP_CMD_ZERO;
    endcase
    if (limit_flag_reg) cmd_next = `MCP_CMD_ZERO;
  end

  // command register and trapezoid move length counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= `MCP_CMD_ZERO;
      move_cnt_reg <= 8'h00;
    end else begin
      cmd_reg <= cmd_next;
      if (trap_enter) move_cnt_reg <= mem_reg[`MCP_OFS_MOVE];
      else if (state_reg != mcp_pkg::ST_TRAP) move_cnt_reg <= 8'h00;
      else if (sample_tick && move_cnt_reg != 8'h00) begin
        move_cnt_reg <= move_cnt_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // host read path
  // ----------------------------------------------------------------

  wire prof_now = (state_reg == mcp_pkg::ST_TRAP) &
                  (move_cnt_reg != 8'h00);
  wire [7:0] flag_rd = {6'h00, is_idle, prof_now};
  wire [7:0] status_rd = {stop_flag_reg, limit_flag_reg, is_idle,
                          prof_now, cfg_reg};

  // readable view of a location
  wire [7:0] rd_data =
    (addr_eff == `MCP_OFS_FLAG) ? flag_rd :
    (addr_eff == `MCP_OFS_STATUS) ? status_rd :
    (addr_eff == `MCP_OFS_CMD) ? cmd_reg :
    (addr_eff == `MCP_OFS_POS0) ? pos_reg[7:0] :
    (addr_eff == `MCP_OFS_POS1) ? pos_reg[15:8] :
    (addr_eff == `MCP_OFS_POS2) ? pos_reg[23:16] :
    mem_reg[addr_eff];

  // output latch loads on read strobe; pins driven only while enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_latch_reg <= 8'h00;
      drv_reg <= 1'b0;
    end else begin
      if (rd_go) out_latch_reg <= rd_data;
      drv_reg <= ~host_strb.oe_n;
    end
  end

  assign muxed_addr_data_low_out = out_latch_reg[5:0];
  assign data_only_high_out = out_latch_reg[7:6];
  assign muxed_addr_data_low_oe = drv_reg;
  assign data_only_high_oe = drv_reg;

  // ----------------------------------------------------------------
  // pwm and commutator
  // ----------------------------------------------------------------

  logic [6:0] pwm_cnt_reg;

  // magnitude from offset binary, clamped to one full period
  wire neg_cmd = cmd_reg < `MCP_CMD_ZERO;
  wire [7:0] mag_raw = neg_cmd ? (`MCP_CMD_ZERO - cmd_reg) :
                                 (cmd_reg - `MCP_CMD_ZERO);
  wire [6:0] mag = (mag_raw > 8'({1'b0, `MCP_PWM_PERIOD})) ?
                   `MCP_PWM_PERIOD : mag_raw[6:0];
  wire pwm_wrap = (pwm_cnt_reg == `MCP_PWM_PERIOD - 7'h01);

  // quadrant of the ring counter, shifted by the phase advance
  wire [1:0] quad = ring_reg[7:6] + mem_reg[`MCP_OFS_PH_ADV][1:0];
  wire [3:0] phase_sel = 4'h1 << quad;

  // pwm period counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pwm_cnt_reg <= 7'h00;
    else if (pwm_wrap) pwm_cnt_reg <= 7'h00;
    else pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------

  // every pin is a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motor_cmd_out <= `MCP_CMD_ZERO;
      pwm_pulse <= 1'b0;
      pwm_sign <= 1'b0;
      phase_en_out <= 4'h0;
      prof_out <= 1'b0;
      init_out <= 1'b0;
    end else begin
      motor_cmd_out <= cmd_reg;
      pwm_pulse <= pwm_cnt_reg < mag;
      pwm_sign <= neg_cmd;
      phase_en_out <= run_mode ? phase_sel : 4'h0;
      prof_out <= prof_now;
      init_out <= is_idle;
    end
  end

endmodule : mcp_top

/* dv/mcp_top_props.sv */
/*
  concurrent checks on the pins of the motion controller pin shell.
  assumes binding to mcp_top and a single clk_sys domain.
*/
`timescale 1ns/1ps

module mcp_top_props #(
  parameter int POS_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mcp_pkg::mcp_hstrb_t host_strb,
  input wire logic limit_n,
  input wire logic muxed_addr_data_low_oe,
  input wire logic data_only_high_oe,
  input wire logic [7:0] motor_cmd_out,
  input wire logic pwm_pulse,
  input wire logic pwm_sign,
  input wire logic [3:0] phase_en_out,
  input wire logic prof_out,
  input wire logic init_out
);
  // ------------------------------------------------------------
  // command age: cycles the motor command has stood unchanged
  // ------------------------------------------------------------
  logic [7:0] cmd_prev_reg;
  logic [7:0] cmd_age_reg;
  logic [7:0] cmd_age_next;

  assign cmd_age_next = (motor_cmd_out != cmd_prev_reg) ? 8'h00 :
                        (cmd_age_reg == 8'hC8) ? 8'hC8 : cmd_age_reg + 8'h01;

  // age counter, saturating so it never wraps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_prev_reg <= 8'h80;
      cmd_age_reg <= 8'h00;
    end else begin
      cmd_prev_reg <= motor_cmd_out;
      cmd_age_reg <= cmd_age_next;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_oe_follows;
    muxed_addr_data_low_oe == !$past(host_strb.oe_n);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("bus drive not tied to output enable");

  property p_high_oe;
    data_only_high_oe == muxed_addr_data_low_oe;
  endproperty
  a_high_oe: assert property (p_high_oe)
    else $error("high and low bus enables disagree");

  property p_sign;
    cmd_age_reg > 8'h02 |-> pwm_sign == (motor_cmd_out < 8'h80);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign output does not match command polarity");

  property p_pwm_zero;
    (cmd_age_reg > 8'h02 && motor_cmd_out == 8'h80) |-> !pwm_pulse;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero)
    else $error("pwm high with zero command");

  property p_pwm_period;
    ($rose(pwm_pulse) && cmd_age_reg > 8'h04) |->
      ##100 (pwm_pulse || cmd_age_reg < 8'h64);
  endproperty
  a_pwm_period: assert property (p_pwm_period)
    else $error("pwm period is not 100 clocks");

  property p_limit_cmd;
    !limit_n [*3] |=> motor_cmd_out == 8'h80;
  endproperty
  a_limit_cmd: assert property (p_limit_cmd)
    else $error("command not zero under limit");

  property p_limit_idle;
    !limit_n [*3] |=> init_out;
  endproperty
  a_limit_idle: assert property (p_limit_idle)
    else $error("idle output low under limit");

  property p_phase_onehot;
    $onehot0(phase_en_out);
  endproperty
  a_phase_onehot: assert property (p_phase_onehot)
    else $error("more than one phase enabled");

  property p_idle_quiet;
    init_out [*3] |-> (!prof_out && phase_en_out == 4'h0);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("profile or phases active in idle");

  c_prof: cover property ($rose(prof_out));
endmodule : mcp_top_props

bind mcp_top mcp_top_props #(.POS_W(POS_W)) u_props (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .host_strb(host_strb),
  .limit_n(limit_n),
  .muxed_addr_data_low_oe(muxed_addr_data_low_oe),
  .data_only_high_oe(data_only_high_oe),
  .motor_cmd_out(motor_cmd_out),
  .pwm_pulse(pwm_pulse),
  .pwm_sign(pwm_sign),
  .phase_en_out(phase_en_out),
  .prof_out(prof_out),
  .init_out(init_out)
);

/* dv/mcp_host_bfm.sv */
/*
  host processor model on the multiplexed parallel port.
  assumes clk_sys shared with the device; requests move 1 ns after edges.
*/
`timescale 1ns/1ps

module mcp_host_bfm (
  input wire logic clk_sys,
  output mcp_pkg::mcp_hstrb_t host_strb,
  output logic [7:0] bus_lvl,
  input wire logic [5:0] dev_low,
  input wire logic [1:0] dev_high,
  input wire logic dev_oe
);
  logic drv;
  logic [7:0] drv_val;
  logic [7:0] last_reg = 8'h00;

  // wire level; an undriven bus shows the inverse of its last value
  assign bus_lvl = dev_oe ? {dev_high, dev_low} : drv ? drv_val : ~last_reg;

  // remember the last driven level for the floating case
  always_ff @(posedge clk_sys) begin
    if (dev_oe || drv) last_reg <= bus_lvl;
  end

  initial begin
    host_strb = 4'b1111;
    drv = 1'b0;
    drv_val = 8'h00;
  end

  // one bus step of two clocks, strobes {ale_n,cs_n,rd_wr_n,oe_n}
  task automatic put(input logic [3:0] s, input logic d,
                     input logic [7:0] v);
    repeat (2) @(posedge clk_sys);
    #1;
    host_strb = s;
    drv = d;
    drv_val = v;
  endtask : put

  // arrangement 0 apart, 1 overlapped, 2 strobe inside select
  task automatic xfer(input int arr, input logic rd, input logic [5:0] a,
                      input logic [7:0] wd, output logic [7:0] rdat);
    logic [5:0] p;
    p = (arr == 0) ? 6'b011111 : (arr == 1) ? 6'b010010 : 6'b100010;
    rdat = 8'h00;
    for (int i = 0; i < 3; i++) begin
      put({p[5-2*i], p[4-2*i], rd, 1'b1}, 1'b1, {2'b11, a});
    end
    put({2'b10, rd, 1'b1}, !rd, wd);
    put({2'b11, rd, 1'b1}, !rd, wd);
    if (rd) begin
      put(4'b1110, 1'b0, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1;
      rdat = bus_lvl;
      host_strb = 4'b1111;
    end
    put(4'b1111, 1'b0, 8'h00);
  endtask : xfer
endmodule : mcp_host_bfm

/* dv/mcp_top_tb.sv */
/*
  self-checking bench of the motion controller pin shell.
  assumes the host model and the bound checker.
*/
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin tests_run++; \
  if ((got) !== (exp)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, (exp), (got)); end end
`define WAITFOR(nm, cond) begin \
  for (w = 0; w < 4000 && (cond) !== 1'b1; w++) begin \
  @(posedge clk_sys); #1; end `CHK(nm, 1'b1, (cond)) \
  if ((cond) !== 1'b1) test_done(); end

module mcp_top_tb;
  logic clk_sys = 1'b0;
  logic rst_n, index_in, limit_n, stop_n, sync_n;
  logic [1:0] enc_quad_in, high_out;
  mcp_pkg::mcp_hstrb_t host_strb;
  logic [7:0] bus_lvl, motor_cmd_out, v, p0;
  logic [5:0] low_out;
  logic low_oe, high_oe, pwm_pulse, pwm_sign, prof_out, init_out;
  logic [3:0] phase_en_out;
  logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'hC3};
  logic [7:0] cmds [5] = '{8'hC0, 8'h30, 8'h00, 8'h81, 8'h80};
  int mags [5] = '{64, 80, 100, 1, 0};
  int err_count = 0;
  int tests_run = 0;
  int w, n;

  always #2 clk_sys = ~clk_sys;

  mcp_host_bfm u_host (.clk_sys(clk_sys), .host_strb(host_strb),
    .bus_lvl(bus_lvl), .dev_low(low_out), .dev_high(high_out),
    .dev_oe(low_oe));

  mcp_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_strb(host_strb),
    .muxed_addr_data_low_in(bus_lvl[5:0]),
    .muxed_addr_data_low_out(low_out), .muxed_addr_data_low_oe(low_oe),
    .data_only_high_in(bus_lvl[7:6]), .data_only_high_out(high_out),
    .data_only_high_oe(high_oe), .enc_quad_in(enc_quad_in),
    .index_in(index_in), .limit_n(limit_n), .stop_n(stop_n),
    .sync_n(sync_n), .motor_cmd_out(motor_cmd_out), .pwm_pulse(pwm_pulse),
    .pwm_sign(pwm_sign), .phase_en_out(phase_en_out), .prof_out(prof_out),
    .init_out(init_out));

  // ------------------------------------------------------------
  // access and stimulus tasks
  // ------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(0, 1'b0, a, d, x);
  endtask : wr

  task automatic rd(input logic [5:0] a, input int arr,
                    output logic [7:0] d);
    u_host.xfer(arr, 1'b1, a, 8'h00, d);
  endtask : rd

  // hold each encoder state five clocks, past the filter
  task automatic enc_to(input logic [1:0] e);
    repeat (5) @(posedge clk_sys);
    #1;
    enc_quad_in = e;
  endtask : enc_to

  task automatic sleep(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : sleep

  // main sequence
  initial begin
    {rst_n, enc_quad_in, index_in, limit_n, stop_n, sync_n} = 7'h0F;
    sleep(12);
    rst_n = 1'b1;
    sleep(3);
    `CHK("init_out", 1'b1, init_out)
    `CHK("motor_cmd_out", 8'h80, motor_cmd_out)
    `CHK("phase idle", 4'h0, phase_en_out)
    for (int k = 0; k < 3; k++) begin
      u_host.xfer(k, 1'b0, 6'h0C, pat[k], v);
      rd(6'h0C, k, v);
      `CHK("target", pat[k], v)
    end
    wr(6'h0F, 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr(6'h08, cmds[k]);
      sleep(4);
      `CHK("motor_cmd_out", cmds[k], motor_cmd_out)
      `CHK("pwm_sign", (cmds[k] < 8'h80), pwm_sign)
      n = 0;
      repeat (100) begin
        sleep(1);
        n += (pwm_pulse === 1'b1);
      end
      `CHK("pwm high clocks", mags[k], n)
    end
    rd(6'h12, 0, p0);
    enc_to(2'b10); enc_to(2'b11); enc_to(2'b01); enc_to(2'b00);
    sleep(5);
    enc_quad_in = 2'b10;
    index_in = 1'b0;
    sleep(1);
    enc_quad_in = 2'b00;
    sleep(8);
    index_in = 1'b1;
    rd(6'h12, 0, v);
    `CHK("position up", p0 + 8'h04, v)
    enc_to(2'b01); enc_to(2'b11); enc_to(2'b10); enc_to(2'b00);
    sleep(8);
    rd(6'h12, 0, v);
    `CHK("position down", p0, v)
    wr(6'h0C, 8'h88);
    wr(6'h05, 8'h04);
    `WAITFOR("ramp done", motor_cmd_out === 8'h88)
    `CHK("init_out", 1'b0, init_out)
    `CHK("phase_en_out", 1'b1, $onehot(phase_en_out))
    stop_n = 1'b0;
    sleep(3);
    stop_n = 1'b1;
    `WAITFOR("stopped", motor_cmd_out === 8'h80)
    rd(6'h07, 0, v);
    `CHK("stop flag", 1'b1, v[7])
    wr(6'h07, 8'h05);
    wr(6'h05, 8'h01);
    `WAITFOR("position mode", motor_cmd_out === 8'h88)
    stop_n = 1'b0;
    sleep(3);
    stop_n = 1'b1;
    sleep(40);
    `CHK("stop ignored", 8'h88, motor_cmd_out)
    wr(6'h0C, 8'h84);
    wr(6'h05, 8'h02);
    `WAITFOR("prop velocity", motor_cmd_out === 8'h84)
    limit_n = 1'b0;
    sleep(4);
    `CHK("limit cmd", 8'h80, motor_cmd_out)
    `CHK("limit idle", 1'b1, init_out)
    wr(6'h07, 8'h05);
    rd(6'h07, 0, v);
    `CHK("limit flag held", 1'b1, v[6])
    limit_n = 1'b1;
    wr(6'h05, 8'h00);
    wr(6'h07, 8'h0A);
    rd(6'h07, 1, v);
    `CHK("status", 8'h2A, v)
    wr(6'h29, 8'h03);
    wr(6'h0C, 8'h90);
    wr(6'h05, 8'h03);
    `WAITFOR("prof high", prof_out === 1'b1)
    `CHK("init_out", 1'b0, init_out)
    `WAITFOR("prof low", prof_out === 1'b0)
    wr(6'h05, 8'h00);
    `WAITFOR("back idle", init_out === 1'b1)
    // sync low in idle pins the timer at zero, so the first sample
    // of the new mode falls on the very next cycle
    sync_n = 1'b0;
    wr(6'h0C, 8'h91);
    wr(6'h05, 8'h04);
    sleep(1);
    `CHK("sync tick", 8'h91, motor_cmd_out)
    sync_n = 1'b1;
    test_done();
  end
endmodule : mcp_top_tb
